// ==== core/led_flash_gen.sv ====
/*
  Red indicator pattern generator: steady, dark or one to three flashes
  per sequence, one time unit per slot.
  Assumes a clock enable from the owner and a mode input on the same clock.
*/
`timescale 1ns/1ns
`include "supply_monitor_consts.svh"

module led_flash_gen #(
  parameter int unsigned UNIT_CYC = `LED_UNIT_CYC
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_ce,
  // pattern request
  input supply_monitor_pkg::led_mode_e i_mode,
  // indicator
  output logic o_led
);

  logic [31:0] unit_cnt_r;
  logic [3:0] slot_r;
  logic [2:0] flashes;
  logic led_nxt;

  // slot tick divider
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      unit_cnt_r <= 32'h0;
    end else if (i_ce) begin
      if (unit_cnt_r >= UNIT_CYC - 1) begin
        unit_cnt_r <= 32'h0;
      end else begin
        unit_cnt_r <= unit_cnt_r + 32'h1;
      end
    end
  end

  // slot within one flash sequence
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      slot_r <= 4'h0;
    end else if (i_ce && unit_cnt_r >= UNIT_CYC - 1) begin
      if (slot_r == `LED_SEQ_SLOTS) begin
        slot_r <= 4'h0;
      end else begin
        slot_r <= slot_r + 4'h1;
      end
    end
  end

  always_comb begin
    flashes = 3'h0;
    led_nxt = 1'b0;
    case (i_mode)
      supply_monitor_pkg::LED_DARK: flashes = 3'h0;
      supply_monitor_pkg::LED_STEADY: flashes = 3'h0;
      supply_monitor_pkg::LED_SINGLE: flashes = 3'h1;
      supply_monitor_pkg::LED_DOUBLE: flashes = 3'h2;
      supply_monitor_pkg::LED_TRIPLE: flashes = 3'h3;
      default: flashes = 3'h0;
    endcase
    if (i_mode == supply_monitor_pkg::LED_STEADY) begin
      led_nxt = 1'b1;
    end else begin
      // on in even slots until the flash count is spent
      led_nxt = (slot_r < {flashes, 1'b0}) && !slot_r[0];
    end
  end

  // lit while reset is held
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_led <= 1'b1;
    end else if (i_ce) begin
      o_led <= led_nxt;
    end
  end

endmodule

// ==== core/supply_monitor_consts.svh ====
/*
  Constants of the supply monitor status block: register numbers, frame
  offsets, field positions, reset values and timing counts.
  Assumes inclusion by bare name from the design files.
*/
`ifndef SUPPLY_MONITOR_CONSTS_SVH
`define SUPPLY_MONITOR_CONSTS_SVH

// register numbers for acyclic access
`define REGNUM_STATUS 8'h00
`define REGNUM_DIPCNT 8'h02

// function model codes
`define FM_STANDARD 8'h01
`define FM_BUSCTRL 8'hfe

// cyclic frame offsets, standard model
`define STD_OFS_STATUS 8'h01
`define STD_OFS_DIPCNT 8'h02

// positions within the controller object, model 254
`define BC_OFS_STATUS 8'h00
`define BC_OFS_DIPCNT 8'h02

// status byte fields
`define STATUS_FUSE_BIT 0
`define STATUS_SUPPLY_BIT 1

// reset values
`define STATUS_RESET 8'h00
`define DIPCNT_RESET 8'h00

// logical slots occupied on the controller
`define CAN_DIGITAL_SLOTS 4'h1

// clock rate and bus cycle timing
`define CLK_KHZ 20000
`define MIN_CYCLE_US 100
`define MIN_CYCLE_CYC ((`MIN_CYCLE_US * `CLK_KHZ) / 1000)

// indicator flash timing
`define LED_UNIT_MS 200
`define LED_UNIT_CYC (`LED_UNIT_MS * `CLK_KHZ)
`define LED_SEQ_SLOTS 4'hf

`endif

// ==== core/supply_monitor_pkg.sv ====
/*
  Types shared by the supply monitor status block.
  Assumes the constants header is on the include path.
*/
package supply_monitor_pkg;

  // status byte as read by the controller
  typedef struct packed {
    logic [5:0] reserved;
    logic supply_low_flag;
    logic fuse_fault_flag;
  } status_s;

  // red indicator patterns
  typedef enum logic [2:0] {
    LED_DARK,
    LED_STEADY,
    LED_SINGLE,
    LED_DOUBLE,
    LED_TRIPLE
  } led_mode_e;

  // one read answer
  typedef struct packed {
    logic valid;
    logic err;
    logic [7:0] data;
  } rd_answer_s;

endpackage

// ==== core/supply_monitor_status_regs.sv ====
/*
  Supply monitor status block: fuse and feed level flags, voltage dip
  counter, cyclic and acyclic read ports and the red diagnostic indicator.
  Assumes fuse and feed sense lines arrive asynchronously from pins, and
  that the bus side (cycle strobe, read requests) runs on i_clk_sys.
*/
// Functional notes
// - status bit0 fuse fault, bit1 supply low
// - status byte is read only, cyclic
// - dips counted in 8-bit counter 0..255
// - standard model frame offsets 1 and 2
// - acyclic reads use register numbers 0, 2
// - model 254 positions 0 and 2
// - occupies one digital logical slot
// - red dark when no fault present
// - red steady on error or reset
// - single flash on fuse defect
// - double flash on low supply
// - triple flash on both with internal supply
// - refresh frame data every bus cycle
`timescale 1ns/1ns
`include "supply_monitor_consts.svh"

module supply_monitor_status_regs #(
  parameter int unsigned LED_UNIT_CYC = `LED_UNIT_CYC
) (
  // clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_ce,
  // supply sense pins
  input wire logic i_fuse_bad,
  input wire logic i_supply_low,
  input wire logic i_int_supply_ok,
  // module state from local logic
  input wire logic i_module_error,
  // bus cycle and function model
  input wire logic i_cycle_start,
  input wire logic [7:0] i_func_model,
  // cyclic read port
  input wire logic i_cyc_rd,
  input wire logic [7:0] i_cyc_offset,
  output supply_monitor_pkg::rd_answer_s o_cyc_ans,
  // acyclic read port
  input wire logic i_acyc_rd,
  input wire logic [7:0] i_acyc_regnum,
  output supply_monitor_pkg::rd_answer_s o_acyc_ans,
  // diagnostics
  output logic o_cycle_short,
  output logic [3:0] o_can_slots,
  output logic o_led_red
);

  logic [1:0] fuse_sync_r;
  logic [1:0] low_sync_r;
  logic [1:0] int_sync_r;
  logic low_prev_r;
  supply_monitor_pkg::status_s status_r;
  logic [7:0] dip_cnt_r;
  supply_monitor_pkg::status_s frame_status_r;
  logic [7:0] frame_dip_r;
  logic [11:0] cycle_cnt_r;
  logic cycle_seen_r;
  supply_monitor_pkg::led_mode_e led_mode_r;
  supply_monitor_pkg::led_mode_e led_mode_nxt;
  supply_monitor_pkg::rd_answer_s cyc_nxt;
  logic dip_event;
  logic fuse_bad_s;
  logic supply_low_s;
  logic int_ok_s;

  // answer for a selected item: status, counter or unmapped
  function automatic supply_monitor_pkg::rd_answer_s pick(
    input logic hit_status,
    input logic hit_dip,
    input supply_monitor_pkg::status_s st,
    input logic [7:0] cnt
  );
    supply_monitor_pkg::rd_answer_s a;
    a.valid = 1'b1;
    a.err = 1'b0;
    a.data = 8'h00;
    if (hit_status) begin
      a.data = st;
    end else if (hit_dip) begin
      a.data = cnt;
    end else begin
      a.err = 1'b1;
    end
    return a;
  endfunction

  // pin synchronisers
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      fuse_sync_r <= 2'h0;
      low_sync_r <= 2'h0;
      int_sync_r <= 2'h0;
    end else if (i_ce) begin
      fuse_sync_r <= {fuse_sync_r[0], i_fuse_bad};
      low_sync_r <= {low_sync_r[0], i_supply_low};
      int_sync_r <= {int_sync_r[0], i_int_supply_ok};
    end
  end

  assign fuse_bad_s = fuse_sync_r[1];
  assign supply_low_s = low_sync_r[1];
  assign int_ok_s = int_sync_r[1];

  // live status byte, reserved bits read zero
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      status_r <= `STATUS_RESET;
    end else if (i_ce) begin
      status_r.fuse_fault_flag <= fuse_bad_s;
      status_r.supply_low_flag <= supply_low_s;
      status_r.reserved <= 6'h00;
    end
  end

  // dip edge detect on the synchronised level
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      low_prev_r <= 1'b0;
    end else if (i_ce) begin
      low_prev_r <= supply_low_s;
    end
  end

  assign dip_event = supply_low_s && !low_prev_r;

  // dip counter, wraps naturally at 8 bits
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      dip_cnt_r <= `DIPCNT_RESET;
    end else if (i_ce && dip_event) begin
      dip_cnt_r <= dip_cnt_r + 8'h01;
    end
  end

  // frame copy taken at every bus cycle start
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      frame_status_r <= `STATUS_RESET;
      frame_dip_r <= `DIPCNT_RESET;
    end else if (i_ce && i_cycle_start) begin
      frame_status_r <= status_r;
      frame_dip_r <= dip_cnt_r;
    end
  end

  // cycle length watch, flags cycles below the minimum
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      cycle_cnt_r <= 12'h0;
      cycle_seen_r <= 1'b0;
      o_cycle_short <= 1'b0;
    end else if (i_ce) begin
      if (i_cycle_start) begin
        cycle_cnt_r <= 12'h0;
        cycle_seen_r <= 1'b1;
        o_cycle_short <= cycle_seen_r && (cycle_cnt_r < 12'(`MIN_CYCLE_CYC - 1));
      end else if (cycle_cnt_r != 12'hfff) begin
        cycle_cnt_r <= cycle_cnt_r + 12'h1;
      end
    end
  end

  // cyclic read by frame offset of the active model
  always_comb begin
    cyc_nxt = '0;
    if (i_func_model == `FM_BUSCTRL) begin
      cyc_nxt = pick(i_cyc_offset == `BC_OFS_STATUS, i_cyc_offset == `BC_OFS_DIPCNT,
                     frame_status_r, frame_dip_r);
    end else begin
      cyc_nxt = pick(i_cyc_offset == `STD_OFS_STATUS, i_cyc_offset == `STD_OFS_DIPCNT,
                     frame_status_r, frame_dip_r);
    end
  end

  // cyclic answer, one cycle after the request; no write path exists
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_cyc_ans <= '0;
    end else if (i_ce) begin
      if (i_cyc_rd) begin
        o_cyc_ans <= cyc_nxt;
      end else begin
        o_cyc_ans <= '0;
      end
    end
  end

  // acyclic answer by register number, live values
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_acyc_ans <= '0;
    end else if (i_ce) begin
      if (i_acyc_rd) begin
        o_acyc_ans <= pick(i_acyc_regnum == `REGNUM_STATUS, i_acyc_regnum == `REGNUM_DIPCNT,
                           status_r, dip_cnt_r);
      end else begin
        o_acyc_ans <= '0;
      end
    end
  end

  // logical slot count
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_can_slots <= `CAN_DIGITAL_SLOTS;
    end else if (i_ce) begin
      o_can_slots <= `CAN_DIGITAL_SLOTS;
    end
  end

  // indicator pattern priority
  always_comb begin
    led_mode_nxt = supply_monitor_pkg::LED_DARK;
    if (i_module_error) begin
      led_mode_nxt = supply_monitor_pkg::LED_STEADY;
    end else if (fuse_bad_s && supply_low_s && int_ok_s) begin
      led_mode_nxt = supply_monitor_pkg::LED_TRIPLE;
    end else if (fuse_bad_s) begin
      led_mode_nxt = supply_monitor_pkg::LED_SINGLE;
    end else if (supply_low_s) begin
      led_mode_nxt = supply_monitor_pkg::LED_DOUBLE;
    end
  end

  // steady until the first evaluation after reset
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      led_mode_r <= supply_monitor_pkg::LED_STEADY;
    end else if (i_ce) begin
      led_mode_r <= led_mode_nxt;
    end
  end

  led_flash_gen #(
    .UNIT_CYC(LED_UNIT_CYC)
  ) u_led (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_mode(led_mode_r),
    .o_led(o_led_red)
  );

endmodule

// ==== testbench/bus_ctrl_model.sv ====
/* bus controller side: issues one-cycle bus cycle strobes every i_gap clocks.
   assumes the same clock as the status block. */
`timescale 1ns/1ns
module bus_ctrl_model(
  input wire logic i_clk,
  input wire logic i_run,
  input int i_gap,
  output logic o_strobe
);
  int cnt = 0;
  initial o_strobe = 1'b0;
  // only strobes, never writes; spacing set by the bench
  always @(posedge i_clk) begin
    o_strobe <= 1'b0;
    cnt <= cnt + 1;
    if (!i_run) begin
      cnt <= 0;
    end else if (cnt >= i_gap - 1) begin
      o_strobe <= 1'b1;
      cnt <= 0;
    end
  end
endmodule

// ==== testbench/supply_monitor_chk.sv ====
/* checker: read latency, refusals, short flag hold between strobes and indicator relations.
   assumes binding to the status block top module. */
`timescale 1ns/1ns
module supply_monitor_chk(
  input wire logic i_clk_sys, i_rstn, i_ce, i_fuse_bad, i_supply_low, i_module_error,
  input wire logic i_cycle_start, i_cyc_rd, i_acyc_rd, o_cycle_short, o_led_red,
  input wire logic [7:0] i_func_model, i_cyc_offset, i_acyc_regnum,
  input wire logic [3:0] o_can_slots,
  input supply_monitor_pkg::rd_answer_s o_cyc_ans, o_acyc_ans
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  property p_cyc_ans; i_ce && i_cyc_rd |=> o_cyc_ans.valid; endproperty
  a_cyc_ans: assert property (p_cyc_ans) else $error("cyclic answer missing");
  property p_cyc_quiet; i_ce && !i_cyc_rd |=> !o_cyc_ans.valid; endproperty
  a_cyc_quiet: assert property (p_cyc_quiet) else $error("cyclic answer unasked");
  property p_std_map;
    i_ce && i_cyc_rd && i_func_model != 8'hfe && i_cyc_offset inside {8'h01, 8'h02} |=> !o_cyc_ans.err;
  endproperty
  a_std_map: assert property (p_std_map) else $error("standard offset refused");
  property p_bc_map;
    i_ce && i_cyc_rd && i_func_model == 8'hfe && !(i_cyc_offset inside {8'h00, 8'h02})
      |=> o_cyc_ans.err && o_cyc_ans.data == 8'h00;
  endproperty
  a_bc_map: assert property (p_bc_map) else $error("model 254 offset accepted");
  property p_acyc_map;
    i_ce && i_acyc_rd |=> o_acyc_ans.valid && (o_acyc_ans.err == !($past(i_acyc_regnum) inside {8'h00, 8'h02}));
  endproperty
  a_acyc_map: assert property (p_acyc_map) else $error("acyclic number decode wrong");
  property p_slots; o_can_slots == 4'h1; endproperty
  a_slots: assert property (p_slots) else $error("slot count wrong");
  property p_short_hold; !(i_ce && i_cycle_start) |=> $stable(o_cycle_short); endproperty
  a_short_hold: assert property (p_short_hold) else $error("short flag moved");
  property p_led_err; (i_ce && i_module_error) [*2] |=> o_led_red; endproperty
  a_led_err: assert property (p_led_err) else $error("indicator dark on error");
  property p_led_dark; (i_ce && !i_module_error && !i_fuse_bad && !i_supply_low) [*7] |=> !o_led_red; endproperty
  a_led_dark: assert property (p_led_dark) else $error("indicator lit without fault");
  c_cyc: cover property (i_cyc_rd ##1 o_cyc_ans.valid);
  c_err: cover property (o_acyc_ans.err);
  c_short: cover property ($rose(o_cycle_short));
endmodule
bind supply_monitor_status_regs supply_monitor_chk chk_i(.i_clk_sys, .i_rstn, .i_ce, .i_fuse_bad,
  .i_supply_low, .i_module_error, .i_cycle_start, .i_cyc_rd, .i_acyc_rd, .o_cycle_short, .o_led_red,
  .i_func_model, .i_cyc_offset, .i_acyc_regnum, .o_can_slots, .o_cyc_ans, .o_acyc_ans);

// ==== testbench/supply_monitor_status_regs_bench.sv ====
/* bench: pin stimulus, cyclic and acyclic reads, strobe spacing, indicator patterns.
   assumes the checker is bound and the controller model supplies strobes. */
`timescale 1ns/1ns
module supply_monitor_status_regs_bench;
  logic i_clk_sys = 0, i_rstn = 0, i_ce = 1, i_fuse_bad = 0, i_supply_low = 0, i_int_supply_ok = 1;
  logic i_module_error = 0, i_cyc_rd = 0, i_acyc_rd = 0, i_cycle_start, o_cycle_short, o_led_red, run = 0;
  logic [7:0] i_func_model = 8'h01, i_cyc_offset = 8'h00, i_acyc_regnum = 8'h00;
  logic [3:0] o_can_slots;
  logic [31:0] seed = 32'd89033;
  supply_monitor_pkg::rd_answer_s o_cyc_ans, o_acyc_ans;
  int n_mismatch = 0, num_checks = 0, cyc = 0, dips = 0, gap = 2000, lit;
  logic [3:0] pins[6] = '{4'h1, 4'h9, 4'h5, 4'h3, 4'h7, 4'h6};
  int flashes[6] = '{0, 16, 1, 2, 3, 1};
  supply_monitor_status_regs #(.LED_UNIT_CYC(4)) dut(.i_clk_sys, .i_rstn, .i_ce, .i_fuse_bad,
    .i_supply_low, .i_int_supply_ok, .i_module_error, .i_cycle_start, .i_func_model, .i_cyc_rd,
    .i_cyc_offset, .o_cyc_ans, .i_acyc_rd, .i_acyc_regnum, .o_acyc_ans, .o_cycle_short, .o_can_slots, .o_led_red);
  bus_ctrl_model bc(.i_clk(i_clk_sys), .i_run(run), .i_gap(gap), .o_strobe(i_cycle_start));
  always #25 i_clk_sys = ~i_clk_sys;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [9:0] exp_ans(input logic bcm, input logic cycp, input logic [7:0] a);
    if (a == ((cycp && !bcm) ? 8'h01 : 8'h00)) return {2'b10, 6'h00, i_supply_low, i_fuse_bad};
    if (a == 8'h02) return {2'b10, dips[7:0]};
    return 10'h300;
  endfunction
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic set_pins(input logic [3:0] p);
    @(posedge i_clk_sys);
    if (p[1] && !i_supply_low) dips = (dips + 1) % 256;
    {i_module_error, i_fuse_bad, i_supply_low, i_int_supply_ok} <= p;
    repeat (5) @(posedge i_clk_sys);
  endtask
  task automatic rd(input logic cycp, input logic [7:0] a, input logic [9:0] e);
    @(posedge i_clk_sys);
    if (cycp) begin
      i_cyc_rd <= 1'b1;
      i_cyc_offset <= a;
    end else begin
      i_acyc_rd <= 1'b1;
      i_acyc_regnum <= a;
    end
    @(posedge i_clk_sys);
    i_cyc_rd <= 1'b0;
    i_acyc_rd <= 1'b0;
    #1 chk(cycp ? "cyclic" : "acyclic", e, cycp ? o_cyc_ans : o_acyc_ans);
  endtask
  task automatic print_verdict;
    if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      print_verdict;
    end
  end
  initial begin
    repeat (3) @(posedge i_clk_sys);
    #1 chk("slots", 10'h001, {6'h00, o_can_slots});
    chk("led", 10'h001, {9'h000, o_led_red});
    repeat (3) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    repeat (1100) begin
      seed = lfsr(seed);
      set_pins({1'b0, seed[1:0], 1'b1});
      rd(1'b0, 8'h00, exp_ans(1'b0, 1'b0, 8'h00));
      rd(1'b0, 8'h02, exp_ans(1'b0, 1'b0, 8'h02));
      rd(1'b0, {5'h00, seed[9:7]}, exp_ans(1'b0, 1'b0, {5'h00, seed[9:7]}));
    end
    // frozen enable: no answer, dip seen only once enable returns
    set_pins(4'h1);
    i_ce <= 1'b0;
    set_pins(4'h3);
    rd(1'b0, 8'h02, 10'h000);
    @(posedge i_clk_sys);
    i_ce <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    rd(1'b0, 8'h02, exp_ans(1'b0, 1'b0, 8'h02));
    for (int g = 1999; g <= 2000; g++) begin
      @(posedge i_clk_sys);
      gap <= g;
      run <= 1'b1;
      repeat (2 * g + 20) @(posedge i_clk_sys);
      run <= 1'b0;
      #1 chk("short", {9'h000, g < 2000}, {9'h000, o_cycle_short});
    end
    for (int m = 0; m < 2; m++) begin
      i_func_model <= m ? 8'hfe : 8'h01;
      for (int a = 0; a < 4; a++) rd(1'b1, a[7:0], exp_ans(m[0], 1'b1, a[7:0]));
    end
    for (int i = 0; i < 6; i++) begin
      set_pins(pins[i]);
      repeat (80) @(posedge i_clk_sys);
      lit = 0;
      repeat (64) begin
        @(posedge i_clk_sys);
        #1 lit += o_led_red;
      end
      chk("lit", 10'(flashes[i] * 4), 10'(lit));
    end
    print_verdict;
  end
endmodule
